// [verilog/ledkp_pkg.sv]
`default_nettype none
package ledkp_pkg;

    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned KEY_STEP_US   = 64;
    localparam int unsigned KEY_SAMPLE_US = 60;
    localparam int unsigned BLANK_US      = 32;
    localparam int unsigned KEY_STEP_CYC   = KEY_STEP_US * CLK_MHZ;
    localparam int unsigned KEY_SAMPLE_CYC = KEY_SAMPLE_US * CLK_MHZ;
    // One sixteenth of a digit slot equals one blanking interval.
    localparam int unsigned PART_CYC       = BLANK_US * CLK_MHZ;

    localparam int unsigned DIGITS = 6;

    localparam logic [3:0] FIRST_PART = 4'h0;
    localparam logic [3:0] LAST_PART  = 4'hf;
    localparam logic [3:0] MAX_ON     = 4'he;
    localparam logic [3:0] LAST_LINE  = 4'h7;
    localparam logic [2:0] LAST_DIGIT = 3'h5;

    localparam logic [1:0] PAGE_DISP    = 2'h0;
    localparam logic [1:0] PAGE_LED     = 2'h1;
    localparam logic [1:0] PAGE_DIM     = 2'h2;
    localparam logic [1:0] PAGE_LED_DIM = 2'h3;

    localparam logic [2:0] ADDR_LED_READBACK = 3'h0;
    localparam logic [2:0] ADDR_KEY_ONE      = 3'h1;
    localparam logic [2:0] ADDR_KEY_TWO      = 3'h2;

    localparam int unsigned CMD_FIXED_BIT = 5;
    localparam int unsigned CMD_READ_BIT  = 6;
    localparam logic [4:0]  CMD_DISP_ON   = 5'h0d;
    localparam logic [4:0]  CMD_DISP_OFF  = 5'h0e;

    localparam logic [7:0] DIM_CFG_RESET = 8'hfb;
    localparam logic [7:0] KEY_RESET     = 8'h00;
    localparam logic [1:0] CONST_MODE    = 2'h3;

    // Digit on-time, LED off-time, in sixteenths for each three-bit brightness code.
    localparam logic [7:0][3:0] BRIGHT_LUT = {4'he, 4'hd, 4'hc, 4'hb,
                                              4'ha, 4'h4, 4'h2, 4'h1};

    typedef enum logic [1:0] {
        LEDKP_PH_KEY,
        LEDKP_PH_LED,
        LEDKP_PH_DIGIT
    } ledkp_phase_e;

endpackage
`default_nettype wire

// [verilog/ledkp_ser_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ledkp_ser_if;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rx_first;
    logic       active;
    logic       tx_done;
    logic [7:0] tx_byte;
    logic       rd_mode;

    modport ser  (output rx_byte, rx_valid, rx_first, active, tx_done,
                  input  tx_byte, rd_mode);
    modport core (input  rx_byte, rx_valid, rx_first, active, tx_done,
                  output tx_byte, rd_mode);
endinterface
`default_nettype wire

// [verilog/ledkp_serial.sv]
`timescale 1ns/1ps
`default_nettype none
module ledkp_serial (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic link_clk,
    input  wire logic frame_select_n,
    input  wire logic data_in,
    output logic      data_out,
    output logic      data_oe_n,
    ledkp_ser_if.ser  bus
);

    typedef struct packed {
        logic [2:0] clk_sy;
        logic [1:0] stb_sy;
        logic [1:0] din_sy;
        logic [7:0] shreg;
        logic [7:0] txreg;
        logic [2:0] cnt;
        logic       first;
        logic       rx_valid;
        logic       rx_first;
        logic [7:0] rx_byte;
        logic       tx_done;
        logic       dout;
        logic       oe_n;
        logic       active;
    } ledkp_ser_s;

    ledkp_ser_s s;
    ledkp_ser_s next_s;
    logic       rise;
    logic       fall;

    assign rise = s.clk_sy[1] & ~s.clk_sy[2];
    assign fall = ~s.clk_sy[1] & s.clk_sy[2];

    always_comb begin
        next_s          = s;
        next_s.clk_sy   = {s.clk_sy[1:0], link_clk};
        next_s.stb_sy   = {s.stb_sy[0], frame_select_n};
        next_s.din_sy   = {s.din_sy[0], data_in};
        next_s.rx_valid = 1'b0;
        next_s.tx_done  = 1'b0;
        if (s.stb_sy[1]) begin
            // A strobe rise drops any partial byte.
            next_s.cnt    = 3'h0;
            next_s.first  = 1'b1;
            next_s.oe_n   = 1'b1;
            next_s.dout   = 1'b1;
            next_s.active = 1'b0;
        end else begin
            next_s.active = 1'b1;
            if (fall && bus.rd_mode) begin
                next_s.oe_n = 1'b0;
                if (s.cnt == 3'h0) begin
                    // Least significant bit leaves first.
                    next_s.dout  = bus.tx_byte[0];
                    next_s.txreg = {1'b0, bus.tx_byte[7:1]};
                end else begin
                    next_s.dout  = s.txreg[0];
                    next_s.txreg = {1'b0, s.txreg[7:1]};
                end
            end
            if (rise) begin
                next_s.shreg = {s.din_sy[1], s.shreg[7:1]};
                next_s.cnt   = s.cnt + 3'h1;
                if (s.cnt == 3'h7) begin
                    if (bus.rd_mode) begin
                        next_s.tx_done = 1'b1;
                    end else begin
                        // The first byte of a frame is flagged.
                        next_s.rx_valid = 1'b1;
                        next_s.rx_byte  = {s.din_sy[1], s.shreg[7:1]};
                        next_s.rx_first = s.first;
                        next_s.first    = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s        <= '0;
            s.stb_sy <= 2'h3;
            s.first  <= 1'b1;
            s.oe_n   <= 1'b1;
            s.dout   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign bus.rx_byte  = s.rx_byte;
    assign bus.rx_valid = s.rx_valid;
    assign bus.rx_first = s.rx_first;
    assign bus.active   = s.active;
    assign bus.tx_done  = s.tx_done;
    assign data_out     = s.dout;
    assign data_oe_n    = s.oe_n;

    strobe_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s.stb_sy[1] |=> (s.cnt == 3'h0 && !s.rx_valid && !s.tx_done))
        else $error("partial byte survived a strobe rise");

    tx_lsb_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (fall && bus.rd_mode && s.cnt == 3'h0 && !s.stb_sy[1])
        |=> (data_out == $past(bus.tx_byte[0]) && !data_oe_n))
        else $error("read byte did not start with its lowest bit");

endmodule // ledkp_serial
`default_nettype wire

// [verilog/ledkp_top.sv]
// What this block does
// - Every grid is off during the first and last sixteenth of a digit.
// - Key scan keeps grids off, drives one segment line at a time, 64 us.
// - Both key returns are sampled 60 us into each segment step.
// - LED slot lights only the LED grid, segments from data and brightness.
// - LED brightness is off time within a 14/16 on window.
// - Digit slots use common or per-digit dimming, 1/16 to 14/16.
// - A 32 us blank precedes each grid turning on and follows its turning off.
// - Digits step up to the configured count, then key scan restarts.
// - With display off the digit slots are skipped entirely.
// - After reset all segment and grid outputs are off.
// - A changed key state drives the low interrupt as a level.
// - Interrupt clears only when the key byte is fully read out.
// - A second-byte key keeps interrupt low until that byte is read.
// - Key bytes return LSB first, return line a then b.
// - Key bytes start at zero and follow sampled presses.
// - First byte after strobe falls is the command, later bytes data.
// - Strobe rising mid byte drops the partial byte only.
// - Command: address 2:0, page 4:3, fixed 5, read 6, bit 7 ignored.
// - Write commands latch display and address mode flags, reset off.
// - Write command low bits 01101 turns display on, 01110 off.
// - Page one reads give Discrete_led_readback, key byte one, key byte two.
// - Page one reads start at the command address, stop after three.
// - Digit count field 000 to 101 selects one to six digits.
// - Brightness codes map to 1,2,4,10,11,12,13,14 sixteenths.
// - Auto mode advances the pointer per data byte, fixed mode holds.
`timescale 1ns/1ps
`default_nettype none
module ledkp_top #(
    parameter int unsigned KEY_STEP_CYC   = ledkp_pkg::KEY_STEP_CYC,
    parameter int unsigned KEY_SAMPLE_CYC = ledkp_pkg::KEY_SAMPLE_CYC,
    parameter int unsigned PART_CYC       = ledkp_pkg::PART_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       link_clk,
    input  wire logic       frame_select_n,
    input  wire logic       data_in,
    input  wire logic       key_return_a,
    input  wire logic       key_return_b,
    output logic            data_out,
    output logic            data_oe_n,
    output logic [7:0]      seg_out,
    output logic [5:0]      grid_out,
    output logic            led_grid,
    output logic            key_irq_n
);

    localparam logic [15:0] STEP_LAST   = 16'(KEY_STEP_CYC - 1);
    localparam logic [15:0] SAMPLE_LAST = 16'(KEY_SAMPLE_CYC - 1);
    localparam logic [15:0] PART_LAST   = 16'(PART_CYC - 1);

    typedef struct packed {
        ledkp_pkg::ledkp_phase_e phase;
        logic [15:0]             cyc;
        logic [3:0]              sub;
        logic [2:0]              digit;
        logic [1:0]              ka_sy;
        logic [1:0]              kb_sy;
        logic [7:0]              scan_a;
        logic [7:0]              scan_b;
        logic [7:0]              key_a;
        logic [7:0]              key_b;
        logic                    irq_a;
        logic                    irq_b;
        logic                    disp_on;
        logic                    fixed;
        logic                    rd;
        logic [1:0]              page;
        logic [2:0]              ptr;
        logic [7:0]              discrete_led_readback;
        logic [5:0][7:0]         disp;
        logic [3:0][7:0]         dim;
        logic [3:0][7:0]         led_dim;
        logic [7:0]              seg_out;
        logic [5:0]              grid_out;
        logic                    led_grid;
        logic                    irq_n;
    } ledkp_core_s;

    ledkp_core_s s;
    ledkp_core_s next_s;
    ledkp_ser_if ser_bus ();

    ledkp_serial u_serial (
        .ref_clk        (ref_clk),
        .sys_rst        (sys_rst),
        .link_clk       (link_clk),
        .frame_select_n (frame_select_n),
        .data_in        (data_in),
        .data_out       (data_out),
        .data_oe_n      (data_oe_n),
        .bus            (ser_bus)
    );

    always_comb begin
        logic [3:0] wd;
        logic [2:0] code;
        logic [1:0] idx;
        logic [2:0] last;
        logic [7:0] b;
        logic       part_end;
        logic       key_done;
        logic       const_dim;
        wd        = 4'h0;
        part_end  = 1'b0;
        code      = 3'h0;
        idx       = 2'h0;
        b         = ser_bus.rx_byte;
        key_done  = 1'b0;
        const_dim = (s.dim[0][4:3] == ledkp_pkg::CONST_MODE);
        // Digit count codes above six digits are clipped.
        last      = (s.dim[0][2:0] > ledkp_pkg::LAST_DIGIT) ?
                    ledkp_pkg::LAST_DIGIT : s.dim[0][2:0];
        next_s          = s;
        next_s.ka_sy    = {s.ka_sy[0], key_return_a};
        next_s.kb_sy    = {s.kb_sy[0], key_return_b};
        next_s.seg_out  = 8'h00;
        next_s.grid_out = 6'h00;
        next_s.led_grid = 1'b0;

        case (s.phase)
            ledkp_pkg::LEDKP_PH_KEY: begin
                next_s.seg_out = 8'h01 << s.sub[2:0];
            end
            ledkp_pkg::LEDKP_PH_LED: begin
                next_s.led_grid = (s.sub != ledkp_pkg::FIRST_PART) &&
                                  (s.sub != ledkp_pkg::LAST_PART);
                for (int i = 0; i < 8; i++) begin
                    idx  = 2'(i / 2);
                    code = const_dim ? s.dim[0][7:5] :
                           (i[0] ? s.led_dim[idx][6:4] : s.led_dim[idx][2:0]);
                    wd   = ledkp_pkg::BRIGHT_LUT[code];
                    // Brightness is the off part of the window.
                    next_s.seg_out[i] = s.discrete_led_readback[i] && (s.sub > wd) &&
                                        (s.sub <= ledkp_pkg::MAX_ON);
                end
            end
            ledkp_pkg::LEDKP_PH_DIGIT: begin
                idx  = 2'(s.digit[2:1] + 2'h1);
                code = const_dim ? s.dim[0][7:5] :
                       (s.digit[0] ? s.dim[idx][6:4] : s.dim[idx][2:0]);
                wd   = ledkp_pkg::BRIGHT_LUT[code];
                // Part 0 and the parts after the window are blank.
                if (s.sub != ledkp_pkg::FIRST_PART && s.sub <= wd) begin
                    next_s.grid_out = 6'h01 << s.digit;
                    next_s.seg_out  = s.disp[s.digit];
                end
            end
            default: ;
        endcase

        // Slot timing runs off the local clock alone.
        part_end = (s.phase == ledkp_pkg::LEDKP_PH_KEY) ?
                   (s.cyc == STEP_LAST) : (s.cyc == PART_LAST);
        next_s.cyc = part_end ? 16'h0000 : s.cyc + 16'h0001;
        case (s.phase)
            ledkp_pkg::LEDKP_PH_KEY: begin
                if (s.cyc == SAMPLE_LAST) begin
                    next_s.scan_a[s.sub[2:0]] = s.ka_sy[1];
                    next_s.scan_b[s.sub[2:0]] = s.kb_sy[1];
                end
                if (part_end) begin
                    next_s.sub = s.sub + 4'h1;
                    if (s.sub == ledkp_pkg::LAST_LINE) begin
                        key_done     = 1'b1;
                        next_s.sub   = 4'h0;
                        next_s.digit = 3'h0;
                        if (s.discrete_led_readback != 8'h00) begin
                            next_s.phase = ledkp_pkg::LEDKP_PH_LED;
                        end else if (s.disp_on) begin
                            next_s.phase = ledkp_pkg::LEDKP_PH_DIGIT;
                        end
                    end
                end
            end
            ledkp_pkg::LEDKP_PH_LED: begin
                if (part_end) begin
                    next_s.sub = s.sub + 4'h1;
                    if (s.sub == ledkp_pkg::LAST_PART) begin
                        next_s.phase = s.disp_on ? ledkp_pkg::LEDKP_PH_DIGIT :
                                       ledkp_pkg::LEDKP_PH_KEY;
                    end
                end
            end
            ledkp_pkg::LEDKP_PH_DIGIT: begin
                if (!s.disp_on) begin
                    next_s.phase = ledkp_pkg::LEDKP_PH_KEY;
                    next_s.cyc   = 16'h0000;
                    next_s.sub   = 4'h0;
                end else if (part_end) begin
                    next_s.sub = s.sub + 4'h1;
                    if (s.sub == ledkp_pkg::LAST_PART) begin
                        if (s.digit >= last) begin
                            next_s.phase = ledkp_pkg::LEDKP_PH_KEY;
                            next_s.digit = 3'h0;
                        end else begin
                            next_s.digit = s.digit + 3'h1;
                        end
                    end
                end
            end
            default: begin
                next_s.phase = ledkp_pkg::LEDKP_PH_KEY;
            end
        endcase

        if (!ser_bus.active) begin
            next_s.rd = 1'b0;
        end
        if (ser_bus.rx_valid) begin
            if (ser_bus.rx_first) begin
                // Command decode; bit 7 takes no part.
                next_s.page  = b[4:3];
                next_s.ptr   = b[2:0];
                next_s.fixed = b[ledkp_pkg::CMD_FIXED_BIT];
                next_s.rd    = b[ledkp_pkg::CMD_READ_BIT];
                if (!b[ledkp_pkg::CMD_READ_BIT]) begin
                    if (b[4:0] == ledkp_pkg::CMD_DISP_ON) begin
                        next_s.disp_on = 1'b1;
                    end else if (b[4:0] == ledkp_pkg::CMD_DISP_OFF) begin
                        next_s.disp_on = 1'b0;
                    end
                end
            end else if (!s.rd) begin
                case (s.page)
                    ledkp_pkg::PAGE_DISP: begin
                        if (s.ptr <= ledkp_pkg::LAST_DIGIT) begin
                            next_s.disp[s.ptr] = b;
                        end
                    end
                    ledkp_pkg::PAGE_LED: begin
                        if (s.ptr == ledkp_pkg::ADDR_LED_READBACK) begin
                            next_s.discrete_led_readback = b;
                        end
                    end
                    ledkp_pkg::PAGE_DIM: begin
                        if (!s.ptr[2]) next_s.dim[s.ptr[1:0]] = b;
                    end
                    ledkp_pkg::PAGE_LED_DIM: begin
                        if (!s.ptr[2]) next_s.led_dim[s.ptr[1:0]] = b;
                    end
                    default: ;
                endcase
                if (!s.fixed) begin
                    next_s.ptr = s.ptr + 3'h1;
                end
            end
        end
        if (ser_bus.tx_done && s.page == ledkp_pkg::PAGE_LED) begin
            // A key byte read to its end clears its flag.
            if (s.ptr == ledkp_pkg::ADDR_KEY_ONE) next_s.irq_a = 1'b0;
            if (s.ptr == ledkp_pkg::ADDR_KEY_TWO) next_s.irq_b = 1'b0;
            if (!s.fixed && s.ptr < ledkp_pkg::ADDR_KEY_TWO) begin
                next_s.ptr = s.ptr + 3'h1;
            end
        end
        if (key_done) begin
            // Set after clear, so a change in the same cycle as a clear is not lost.
            if (next_s.scan_a != s.key_a) next_s.irq_a = 1'b1;
            if (next_s.scan_b != s.key_b) next_s.irq_b = 1'b1;
            next_s.key_a = next_s.scan_a;
            next_s.key_b = next_s.scan_b;
        end
        next_s.irq_n = ~(next_s.irq_a | next_s.irq_b);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s        <= '0;
            s.phase  <= ledkp_pkg::LEDKP_PH_KEY;
            s.dim[0] <= ledkp_pkg::DIM_CFG_RESET;
            s.key_a  <= ledkp_pkg::KEY_RESET;
            s.key_b  <= ledkp_pkg::KEY_RESET;
            s.irq_n  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Page one read data; other pages read back as zero.
    assign ser_bus.tx_byte =
        (s.page != ledkp_pkg::PAGE_LED)         ? 8'h00 :
        (s.ptr == ledkp_pkg::ADDR_LED_READBACK) ? s.discrete_led_readback :
        (s.ptr == ledkp_pkg::ADDR_KEY_ONE)      ? s.key_a :
        (s.ptr == ledkp_pkg::ADDR_KEY_TWO)      ? s.key_b : 8'h00;
    assign ser_bus.rd_mode = s.rd;
    assign seg_out   = s.seg_out;
    assign grid_out  = s.grid_out;
    assign led_grid  = s.led_grid;
    assign key_irq_n = s.irq_n;

    sequence scan_done_s;
        s.phase == ledkp_pkg::LEDKP_PH_KEY && s.cyc == STEP_LAST &&
        s.sub == ledkp_pkg::LAST_LINE;
    endsequence

    sequence key_change_s;
        scan_done_s ##1 (s.key_a != $past(s.key_a) ||
                         s.key_b != $past(s.key_b));
    endsequence

    grid_blank_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (s.sub == ledkp_pkg::FIRST_PART || s.sub == ledkp_pkg::LAST_PART)
        |=> (grid_out == 6'h00 && !led_grid))
        else $error("grid lit in a blanking part");

    keyscan_line_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s.phase == ledkp_pkg::LEDKP_PH_KEY
        |=> ($onehot(seg_out) && grid_out == 6'h00 && !led_grid))
        else $error("key scan not one line with grids off");

    key_irq_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        key_change_s |-> !key_irq_n)
        else $error("key change did not raise the interrupt");

    irq_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!key_irq_n && !ser_bus.tx_done) |=> !key_irq_n)
        else $error("interrupt cleared without a finished read");

    second_byte_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (s.irq_b && ser_bus.tx_done && s.ptr == ledkp_pkg::ADDR_KEY_ONE)
        |=> (s.irq_b && !key_irq_n))
        else $error("first byte read cleared a second byte event");

    disp_skip_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!s.disp_on && s.phase == ledkp_pkg::LEDKP_PH_DIGIT)
        |=> s.phase == ledkp_pkg::LEDKP_PH_KEY ##1 grid_out == 6'h00)
        else $error("digit slot ran with display off");

    reset_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(sys_rst) |-> (seg_out == 8'h00 && grid_out == 6'h00 &&
                            !led_grid && key_irq_n))
        else $error("outputs not off after reset");

    disp_cmd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ser_bus.rx_valid && ser_bus.rx_first && !ser_bus.rx_byte[6] &&
         ser_bus.rx_byte[4:0] == ledkp_pkg::CMD_DISP_ON) |=> s.disp_on)
        else $error("display on command ignored");

endmodule // ledkp_top
`default_nettype wire

// [dv/ledkp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module ledkp_host (
    output logic      link_clk,
    output logic      frame_select_n,
    output logic      data_in,
    input  wire logic data_out
);
    initial begin
        link_clk = 1'b1;
        frame_select_n = 1'b1;
        data_in = 1'b0;
    end
    // Command byte first, then n read bytes, LSB first; clock idles high.
    task automatic xfer(input logic [7:0] cmd, input int n,
                        output logic [23:0] rd);
        rd = 24'h0;
        frame_select_n = 1'b0;
        #1000;
        for (int i = 0; i < 8; i++) begin
            link_clk = 1'b0;
            data_in = cmd[i];
            #40;
            link_clk = 1'b1;
            #40;
        end
        for (int i = 0; i < 8 * n; i++) begin
            link_clk = 1'b0;
            #40;
            rd[i] = data_out;
            link_clk = 1'b1;
            #40;
        end
        #1000;
        frame_select_n = 1'b1;
        data_in = ~data_in;
    endtask
endmodule // ledkp_host
`default_nettype wire

// [dv/ledkp_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ledkp_top_tb;
    logic        ref_clk;
    logic        sys_rst;
    logic        key_a;
    logic        key_b;
    wire logic   link_clk;
    wire logic   fsel_n;
    wire logic   din;
    wire logic   dout;
    wire logic   oe_n;
    wire logic [7:0] seg;
    wire logic [5:0] grid;
    wire logic   led_grid;
    wire logic   irq_n;
    int          err_total;
    int          total_checks;
    logic [23:0] rd;
    ledkp_top #(.KEY_STEP_CYC(64), .KEY_SAMPLE_CYC(60), .PART_CYC(32)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .frame_select_n(fsel_n), .data_in(din), .key_return_a(key_a),
        .key_return_b(key_b), .data_out(dout), .data_oe_n(oe_n),
        .seg_out(seg), .grid_out(grid), .led_grid(led_grid),
        .key_irq_n(irq_n));
    ledkp_host host (.link_clk(link_clk), .frame_select_n(fsel_n),
        .data_in(din), .data_out(dout));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic end_sim;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 3000 && irq_n !== lvl; i++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK(irq_n, lvl)
        // Let a whole scan pass with the keys steady, so both bytes are full.
        repeat (600) @(posedge ref_clk);
    endtask
    task automatic t_scan;
        repeat (10) @(posedge ref_clk);
        #1;
        `CHK(seg, 8'h01)
        `CHK(grid, 6'h00)
        repeat (64) @(posedge ref_clk);
        #1;
        `CHK(seg, 8'h02)
    endtask
    task automatic t_keys;
        @(posedge ref_clk) #1;
        key_a = 1'b1;
        key_b = 1'b1;
        wait_irq(1'b0);
        host.xfer(8'h49, 1, rd);
        `CHK(rd[7:0], 8'hff)
        `CHK(irq_n, 1'b0)
        host.xfer(8'h6a, 1, rd);
        `CHK(rd[7:0], 8'hff)
        repeat (8) @(posedge ref_clk);
        `CHK(irq_n, 1'b1)
        `CHK(oe_n, 1'b1)
    endtask
    task automatic t_page_read;
        @(posedge ref_clk) #1;
        key_a = 1'b0;
        wait_irq(1'b0);
        host.xfer(8'h48, 3, rd);
        `CHK(rd, 24'hff0000)
        repeat (8) @(posedge ref_clk);
        `CHK(irq_n, 1'b1)
    endtask
    task automatic t_display;
        int seen;
        host.xfer(8'h0d, 0, rd);
        for (int i = 0; i < 3000 && grid !== 6'h01; i++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK(grid, 6'h01)
        `CHK(led_grid, 1'b0)
        host.xfer(8'hae, 0, rd);
        seen = 0;
        repeat (50) @(posedge ref_clk);
        repeat (2000) begin
            @(posedge ref_clk);
            if (grid !== 6'h00)
                seen++;
        end
        `CHK(seen, 0)
    endtask
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    initial begin
        err_total = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        key_a = 1'b0;
        key_b = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK({seg, grid, led_grid, irq_n}, 16'h0001)
        sys_rst = 1'b0;
        t_scan();
        t_keys();
        t_page_read();
        t_display();
        end_sim();
    end
endmodule // ledkp_top_tb
`default_nettype wire
